// ===== bench/lsd_core_chk.sv
// Purpose: Port assertions for the display core
// Assumes: One clock, synchronous active-high reset
// Notes: Sees only the core ports
`timescale 1ns/100ps
`default_nettype none
module lsd_core_chk #(
  parameter int SYS_DIV = 2,
  parameter int SLOT_SLOW = 4,
  parameter int SLOT_FAST = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [lsd_pkg::ADDR_W-1:0] addr,
  input wire logic [lsd_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [lsd_pkg::DATA_W-1:0] rd_data,
  input wire logic [lsd_pkg::NUM_SEG-1:0][1:0] segment_output,
  input wire logic [lsd_pkg::NUM_COM-1:0][1:0] common_output,
  input wire logic [3:0] drive_voltage_code,
  input wire logic bias_half_select,
  input wire logic osc_running,
  input wire logic bias_gen_on,
  input wire logic vadj_enable,
  input wire logic detect_switch_enable
);
  import lsd_pkg::*;
  // ----------------------------------------
  // Helpers and assertions
  // ----------------------------------------
  function automatic int n_act(logic [3:0][1:0] c);
    n_act = 0;
    for (int i = 0; i < 4; i++) n_act += int'(c[i] == 2'h0 || c[i] == 2'h3);
  endfunction
  // Under third bias no segment may sit at the active common level
  function automatic logic clash(logic [43:0][1:0] s, logic [3:0][1:0] c);
    clash = 1'b0;
    for (int i = 0; i < 44; i++) for (int k = 0; k < 4; k++) clash |= (c[k] inside {2'h0, 2'h3}) && s[i] == c[k];
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rst_drive_a: assert property (disable iff (1'b0) rst |=> segment_output == '1 && common_output == '1)
    else $error("outputs not at full supply after reset");
  rst_mode_a: assert property (disable iff (1'b0) rst |=> !osc_running && !bias_gen_on && vadj_enable
    && !detect_switch_enable && !bias_half_select && drive_voltage_code == 4'h0) else $error("bad reset mode");
  vadj_copy_a: assert property (wr_en && addr == OFS_VADJ |-> ##2 drive_voltage_code == $past(wr_data[3:0], 2))
    else $error("voltage code not taken");
  bias_copy_a: assert property (wr_en && addr == OFS_MODE |-> ##2 bias_half_select == $past(wr_data[3], 2))
    else $error("bias select not taken");
  mode_copy_a: assert property (wr_en && addr == OFS_MODE |-> ##2 {detect_switch_enable, vadj_enable,
    bias_gen_on, osc_running} == {$past(wr_data[6:5], 2), $past(wr_data[1:0], 2)}) else $error("mode bits not taken");
  dark_off_a: assert property (!osc_running [*3] |-> common_output == '1 && segment_output == '1)
    else $error("drive active while stopped");
  one_com_a: assert property (n_act(common_output) == 1 || n_act(common_output) == 4)
    else $error("more than one common active");
  // Only while driving: a dark display holds every pin at full supply
  seg_level_a: assert property (n_act(common_output) == 1 && !$past(bias_half_select) && !bias_half_select
    |-> !clash(segment_output, common_output))
    else $error("segment at active common level");
endmodule
bind lsd_core lsd_core_chk #(.SYS_DIV(SYS_DIV), .SLOT_SLOW(SLOT_SLOW), .SLOT_FAST(SLOT_FAST)) u_chk (.clk, .rst, .addr,
  .wr_data, .wr_en, .rd_en, .rd_data, .segment_output, .common_output, .drive_voltage_code, .bias_half_select,
  .osc_running, .bias_gen_on, .vadj_enable, .detect_switch_enable);
`default_nettype wire

// ===== bench/lsd_core_tb.sv
// Purpose: Self-checking bench for the display core
// Assumes: Shortened oscillator and slot counts
// Notes: Host model issues all bus cycles
`timescale 1ns/100ps
`default_nettype none
module lsd_core_tb;
  import lsd_pkg::*;
  `define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
  // ----------------------------------------
  // Harness and tests
  // ----------------------------------------
  localparam int SD = 2;
  localparam int SS = 4;
  localparam int SF = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data, d;
  logic wr_en, rd_en, bias_half_select, osc_running, bias_gen_on, vadj_enable, detect_switch_enable;
  logic [NUM_SEG-1:0][1:0] segment_output;
  logic [NUM_COM-1:0][1:0] common_output;
  logic [3:0] drive_voltage_code;
  logic [7:0] ram [RAM_WORDS];
  int failures = 0;
  int num_checks = 0;
  int n;
  always #5 clk = ~clk;
  lsd_core #(.SYS_DIV(SD), .SLOT_SLOW(SS), .SLOT_FAST(SF)) dut (.clk, .rst, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .segment_output, .common_output, .drive_voltage_code, .bias_half_select, .osc_running,
    .bias_gen_on, .vadj_enable, .detect_switch_enable);
  lsd_host host (.clk, .addr, .wr_data, .wr_en, .rd_en, .rd_data);
  function automatic logic act(logic [1:0] x);
    return x == 2'h0 || x == 2'h3;
  endfunction
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic check_disp(input logic half);
    logic [1:0] sv;
    logic [1:0] e;
    int c;
    repeat (4) @(posedge clk);
    repeat (64) begin
      @(negedge clk);
      c = 0;
      for (int k = 0; k < 4; k++) if (act(common_output[k])) c = k;
      sv = common_output[c];
      for (int s = 0; s < NUM_SEG; s++) begin
        e = ram[s/2][(s%2)*4+c] ? 2'h3 - sv : (half ? sv : (sv == 2'h3 ? 2'h2 : 2'h1));
        `CHK(segment_output[s], e)
      end
    end
    @(posedge clk);
  endtask
  task automatic slot_len(input int e);
    n = 0;
    repeat (20) @(posedge clk);
    while (act(common_output[0])) @(posedge clk);
    while (!act(common_output[0])) @(posedge clk);
    while (act(common_output[0])) begin n++; @(posedge clk); end
    `CHK(n, e)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(common_output, 8'hFF)
    host.wait_por();
    rchk(OFS_MODE, 8'h20);
    rchk(OFS_BLINK, 8'h00);
    rchk(OFS_VADJ, 8'h00);
    rchk(OFS_STATUS, 8'h10);
    host.wr(OFS_VADJ, 8'h0A);
    @(negedge clk);
    `CHK(drive_voltage_code, 4'hA)
    @(posedge clk);
    host.wr(OFS_MODE, 8'h60);
    @(negedge clk);
    `CHK({vadj_enable, detect_switch_enable}, 2'h3)
    @(posedge clk);
    $display("test reset done");
    host.wr(OFS_PTR, 8'h14);
    host.wr(OFS_DATA, 8'hA1);
    host.wr(OFS_DATA, 8'hB2);
    host.wr(OFS_DATA, 8'hC3);
    rchk(8'h14, 8'hA1);
    rchk(8'h15, 8'hB2);
    rchk(8'h00, 8'hC3);
    rchk(OFS_DATA, 8'h00);
    rchk(8'h30, 8'h00);
    $display("test pointer done");
    for (int k = 0; k < RAM_WORDS; k++) begin
      ram[k] = 8'h0F ^ (8'(k) * 8'h25);
      host.wr(8'(k), ram[k]);
    end
    host.wr(OFS_MODE, 8'h07);
    check_disp(1'b0);
    host.wr(OFS_MODE, 8'h0F);
    @(negedge clk);
    `CHK(bias_half_select, 1'b1)
    check_disp(1'b1);
    host.wr(OFS_MODE, 8'h07);
    slot_len(SS * SD);
    host.wr(OFS_MODE, 8'h17);
    rchk(OFS_MODE, 8'h17);
    slot_len(SF * SD);
    host.wr(OFS_MODE, 8'h07);
    $display("test display done");
    for (int b = 0; b < 4; b++) begin
      host.wr(OFS_BLINK, 8'(b));
      rchk(OFS_BLINK, 8'(b));
    end
    host.wr(OFS_BLINK, 8'h01);
    n = 0;
    repeat (32768) begin
      @(posedge clk);
      n += int'(act(segment_output[0]));
    end
    `CHK(n, 16384)
    $display("test blink done");
    complete_run();
  end
endmodule
`default_nettype wire

// ===== bench/lsd_host.sv
// Purpose: Host model driving the register port
// Assumes: Caller sits just after a rising edge
// Notes: Released lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module lsd_host #(
  parameter int POR_WAIT = 100
) (
  input wire logic clk,
  output logic [lsd_pkg::ADDR_W-1:0] addr,
  output logic [lsd_pkg::DATA_W-1:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  input wire logic [lsd_pkg::DATA_W-1:0] rd_data
);
  import lsd_pkg::*;
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  initial begin
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // Shortened from one millisecond to keep the run small
  task automatic wait_por();
    repeat (POR_WAIT) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rd_data;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== logic/lsd_core.sv
// Purpose: Segment display core: display memory, pointer, mode state, drive waveforms
// Assumes: Single clock, synchronous active-high reset standing in for power-on reset
// Notes: Register port with read data one cycle after the read strobe
//
// Operation
// RL1 - After reset every segment and common output sits at full drive supply.
// RL2 - Reset selects quarter duty with one-third bias.
// RL3 - Oscillator and bias generator stay stopped after reset until enabled.
// RL4 - Display is off after reset, memory not shown until switched on.
// RL5 - Drive-voltage adjustment function is enabled after reset.
// RL6 - Supply-pin detection switch is disabled after reset.
// RL7 - Reset selects the 80 Hz frame rate.
// RL8 - Reset leaves blinking off, blink mode 0.
// RL9 - Host waits one millisecond after power-on before any bus transfer; the bench host model waits POR_WAIT = 100 clocks instead.
// RL10 - 44x4 bit display memory; one lights a segment, zero darkens it.
// RL11 - Memory column k is shown with common line k.
// RL12 - Byte holds even segment in low nibble, next odd segment in high nibble.
// RL13 - Data writes land at the address pointer set by its command.
// RL14 - Pointer advances per data byte and wraps from 15H to 00H.
// RL15 - Oscillator tick drives control timing and frame rate.
// RL16 - Frame rate selectable between 80 Hz and 160 Hz.
// RL17 - Whole-display blink at oscillator divided by 16384, 32768 or 65536.
// RL18 - Bias select switches divider centre resistor out for half bias.
// RL19 - Four-bit drive-voltage code, sixteen levels, steers the switch network.
// RL20 - Drive-voltage code resets to 00H, full supply.
// RL21 - Blink off phase blanks segments; phases are equal.
// RL22 - Frame splits into four equal phases, common 0 to 3.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module lsd_core #(
  parameter int SYS_DIV = lsd_pkg::SYS_DIV,
  parameter int SLOT_SLOW = lsd_pkg::SLOT_SLOW,
  parameter int SLOT_FAST = lsd_pkg::SLOT_FAST
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [lsd_pkg::ADDR_W-1:0] addr,
  input wire logic [lsd_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [lsd_pkg::DATA_W-1:0] rd_data,
  output logic [lsd_pkg::NUM_SEG-1:0][1:0] segment_output,
  output logic [lsd_pkg::NUM_COM-1:0][1:0] common_output,
  output logic [3:0] drive_voltage_code,
  output logic bias_half_select,
  output logic osc_running,
  output logic bias_gen_on,
  output logic vadj_enable,
  output logic detect_switch_enable
);
  import lsd_pkg::*;

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [MODE_W-1:0] mode, next_mode;
  logic [1:0] blink, next_blink;
  logic [3:0] vadj, next_vadj;
  logic [4:0] ptr, next_ptr;
  logic [DATA_W-1:0] ram [RAM_WORDS];
  logic ram_we;
  logic [4:0] ram_wa;
  logic [DATA_W-1:0] next_rd_data;
  logic [1:0] com_idx, next_com_idx;
  logic frame_inv, next_frame_inv;
  logic blink_phase;

  always_comb begin
    next_mode = mode;
    next_blink = blink;
    next_vadj = vadj;
    next_ptr = ptr;
    ram_we = 1'b0;
    ram_wa = ptr;
    if (wr_en) begin
      if (addr <= OFS_RAM_TOP) begin
        ram_we = 1'b1;
        ram_wa = addr[4:0];
      end else begin
        unique case (addr)
          OFS_PTR: begin
            // Out-of-range pointer values fold to the bottom of memory
            next_ptr = (wr_data <= OFS_RAM_TOP) ? wr_data[4:0] : PTR_RST; // [RL13]
          end
          OFS_DATA: begin
            ram_we = 1'b1; // [RL13]
            next_ptr = (ptr >= OFS_RAM_TOP[4:0]) ? PTR_RST : ptr + 5'h01; // [RL14]
          end
          OFS_MODE: next_mode = wr_data[MODE_W-1:0];
          OFS_BLINK: next_blink = wr_data[1:0];
          OFS_VADJ: next_vadj = wr_data[3:0]; // [RL19]
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    next_rd_data = '0;
    if (rd_en) begin
      if (addr <= OFS_RAM_TOP) begin
        next_rd_data = ram[addr[4:0]];
      end else begin
        unique case (addr)
          OFS_PTR: next_rd_data = {3'h0, ptr};
          OFS_MODE: next_rd_data = {1'b0, mode};
          OFS_BLINK: next_rd_data = {6'h00, blink};
          OFS_VADJ: next_rd_data = {4'h0, vadj};
          OFS_STATUS: next_rd_data = {3'h0, blink_phase, frame_inv, com_idx, osc_running};
          default: next_rd_data = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= MODE_RST; // [RL2] [RL3] [RL4] [RL5] [RL6] [RL7]
      blink <= BLINK_RST; // [RL8]
      vadj <= VADJ_RST; // [RL20]
      ptr <= PTR_RST;
      rd_data <= '0;
    end else begin
      mode <= next_mode;
      blink <= next_blink;
      vadj <= next_vadj;
      ptr <= next_ptr;
      rd_data <= next_rd_data;
    end
  end

  // Memory contents are undefined until written, as on the part itself
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[ram_wa] <= wr_data; // [RL10]
    end
  end

  // ------------------------------------------------------------
  // Oscillator tick, frame phases and blink timing
  // ------------------------------------------------------------
  logic [11:0] div_cnt, next_div_cnt;
  logic sys_tick, next_sys_tick;
  logic [7:0] slot_cnt, next_slot_cnt;
  logic [15:0] blink_cnt, next_blink_cnt;
  logic [7:0] slot_len;

  always_comb begin
    next_div_cnt = div_cnt;
    next_sys_tick = 1'b0;
    next_slot_cnt = slot_cnt;
    next_com_idx = com_idx;
    next_frame_inv = frame_inv;
    next_blink_cnt = blink_cnt;
    slot_len = mode[MODE_FRAME_FAST] ? 8'(SLOT_FAST) : 8'(SLOT_SLOW); // [RL16]
    // A stopped oscillator freezes all display timing
    if (mode[MODE_OSC_ON]) begin // [RL3]
      if (div_cnt == 12'(SYS_DIV - 1)) begin
        next_div_cnt = 12'h000;
        next_sys_tick = 1'b1; // [RL15]
      end else begin
        next_div_cnt = div_cnt + 12'h001;
      end
    end else begin
      next_div_cnt = 12'h000;
    end
    if (sys_tick) begin
      next_blink_cnt = blink_cnt + 16'h0001; // [RL17]
      if (slot_cnt >= slot_len - 8'h01) begin
        next_slot_cnt = 8'h00;
        next_com_idx = com_idx + 2'h1; // [RL22]
        if (com_idx == 2'(NUM_COM - 1)) begin
          next_frame_inv = ~frame_inv;
        end
      end else begin
        next_slot_cnt = slot_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt <= 12'h000;
      sys_tick <= 1'b0;
      slot_cnt <= 8'h00;
      com_idx <= 2'h0;
      frame_inv <= 1'b0;
      blink_cnt <= 16'h0000;
    end else begin
      div_cnt <= next_div_cnt;
      sys_tick <= next_sys_tick;
      slot_cnt <= next_slot_cnt;
      com_idx <= next_com_idx;
      frame_inv <= next_frame_inv;
      blink_cnt <= next_blink_cnt;
    end
  end

  // Half-period counter bit gives equal lit and dark phases
  always_comb begin
    unique case (blink)
      2'h0: blink_phase = 1'b1;
      2'h1: blink_phase = ~blink_cnt[BLINK_BIT_1]; // [RL17] [RL21]
      2'h2: blink_phase = ~blink_cnt[BLINK_BIT_2]; // [RL17] [RL21]
      2'h3: blink_phase = ~blink_cnt[BLINK_BIT_3]; // [RL17] [RL21]
    endcase
  end

  // ------------------------------------------------------------
  // Drive waveform levels
  // ------------------------------------------------------------
  logic [NUM_SEG-1:0][1:0] next_seg;
  logic [NUM_COM-1:0][1:0] next_com;
  logic drive_active;
  logic [1:0] sel_lvl, opp_lvl, com_idle, seg_idle;
  logic [DATA_W-1:0] byte_v;
  logic bit_v;

  always_comb begin
    byte_v = '0;
    bit_v = 1'b0;
    // Waveforms need both the oscillator and the bias divider
    drive_active = mode[MODE_DISP_ON] & mode[MODE_OSC_ON] & mode[MODE_BIAS_ON]; // [RL4]
    sel_lvl = frame_inv ? LVL_VSS : LVL_FULL;
    opp_lvl = frame_inv ? LVL_FULL : LVL_VSS;
    if (mode[MODE_HALF_BIAS]) begin // [RL18]
      com_idle = LVL_LOW_MID;
      seg_idle = sel_lvl;
    end else begin
      com_idle = frame_inv ? LVL_HIGH_MID : LVL_LOW_MID;
      seg_idle = frame_inv ? LVL_LOW_MID : LVL_HIGH_MID;
    end
    for (int c = 0; c < NUM_COM; c++) begin
      if (!drive_active) begin
        next_com[c] = LVL_FULL; // [RL1]
      end else begin
        next_com[c] = (2'(c) == com_idx) ? sel_lvl : com_idle; // [RL22]
      end
    end
    for (int s = 0; s < NUM_SEG; s++) begin
      byte_v = ram[s / 2];
      bit_v = byte_v[(s % 2) * NUM_COM + int'(com_idx)]; // [RL11] [RL12]
      if (!drive_active) begin
        next_seg[s] = LVL_FULL; // [RL1]
      end else if (bit_v && blink_phase) begin
        next_seg[s] = opp_lvl; // [RL10]
      end else begin
        next_seg[s] = seg_idle; // [RL21]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      segment_output <= {NUM_SEG{LVL_FULL}}; // [RL1]
      common_output <= {NUM_COM{LVL_FULL}}; // [RL1]
      drive_voltage_code <= VADJ_RST;
      bias_half_select <= MODE_RST[MODE_HALF_BIAS];
      osc_running <= MODE_RST[MODE_OSC_ON];
      bias_gen_on <= MODE_RST[MODE_BIAS_ON];
      vadj_enable <= MODE_RST[MODE_VADJ_EN];
      detect_switch_enable <= MODE_RST[MODE_DETECT_EN];
    end else begin
      segment_output <= next_seg;
      common_output <= next_com;
      drive_voltage_code <= vadj; // [RL19]
      bias_half_select <= mode[MODE_HALF_BIAS]; // [RL18]
      osc_running <= mode[MODE_OSC_ON]; // [RL3]
      bias_gen_on <= mode[MODE_BIAS_ON]; // [RL3]
      vadj_enable <= mode[MODE_VADJ_EN]; // [RL5]
      detect_switch_enable <= mode[MODE_DETECT_EN]; // [RL6]
    end
  end

endmodule

`default_nettype wire

// ===== logic/lsd_pkg.sv
// Purpose: Shared constants for the segment display core
// Assumes: 100 MHz system clock, nominal 32768 Hz display oscillator
// Notes: Register map, field positions, reset values, drive levels and timing counts
package lsd_pkg;

  // ------------------------------------------------------------
  // Bus shape and display geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_SEG = 44;
  localparam int NUM_COM = 4;
  localparam int RAM_WORDS = NUM_SEG / 2;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_RAM_BASE = 8'h00;
  localparam logic [7:0] OFS_RAM_TOP = 8'h15;
  localparam logic [7:0] OFS_PTR = 8'h20;
  localparam logic [7:0] OFS_DATA = 8'h21;
  localparam logic [7:0] OFS_MODE = 8'h22;
  localparam logic [7:0] OFS_BLINK = 8'h23;
  localparam logic [7:0] OFS_VADJ = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h25;

  // ------------------------------------------------------------
  // Mode register fields
  // ------------------------------------------------------------
  localparam int MODE_OSC_ON = 0;
  localparam int MODE_BIAS_ON = 1;
  localparam int MODE_DISP_ON = 2;
  localparam int MODE_HALF_BIAS = 3;
  localparam int MODE_FRAME_FAST = 4;
  localparam int MODE_VADJ_EN = 5;
  localparam int MODE_DETECT_EN = 6;
  localparam int MODE_W = 7;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [6:0] MODE_RST = 7'h20;
  localparam logic [1:0] BLINK_RST = 2'h0;
  localparam logic [3:0] VADJ_RST = 4'h0;
  localparam logic [4:0] PTR_RST = 5'h00;

  // ------------------------------------------------------------
  // Drive level codes; under half bias both mid codes mean half supply
  // ------------------------------------------------------------
  localparam logic [1:0] LVL_VSS = 2'h0;
  localparam logic [1:0] LVL_LOW_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH_MID = 2'h2;
  localparam logic [1:0] LVL_FULL = 2'h3;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int FSYS_HZ = 32768;
  localparam int FRAME_HZ_SLOW = 80;
  localparam int FRAME_HZ_FAST = 160;
  localparam int SYS_DIV = CLK_HZ / FSYS_HZ;
  localparam int SLOT_SLOW = FSYS_HZ / (FRAME_HZ_SLOW * NUM_COM);
  localparam int SLOT_FAST = FSYS_HZ / (FRAME_HZ_FAST * NUM_COM);
  localparam int BLINK_DIV_1 = 16384;
  localparam int BLINK_DIV_2 = 32768;
  localparam int BLINK_DIV_3 = 65536;
  localparam int BLINK_BIT_1 = $clog2(BLINK_DIV_1) - 1;
  localparam int BLINK_BIT_2 = $clog2(BLINK_DIV_2) - 1;
  localparam int BLINK_BIT_3 = $clog2(BLINK_DIV_3) - 1;

endpackage
